/* File: hdl/mii_regs_consts.svh */
// Offsets, field positions, reset values and frame counts of the management registers
`ifndef MII_REGS_CONSTS_SVH
`define MII_REGS_CONSTS_SVH

// Management register offsets
`define REG_BASIC_LINK_STATUS   5'h01
`define REG_PHY_IDENTIFIER_HIGH 5'h02

// Field positions in basic_link_status
`define BIT_CAP_100_FOUR_PAIR     15
`define BIT_CAP_100X_FULL         14
`define BIT_CAP_100X_HALF         13
`define BIT_CAP_10M_FULL          12
`define BIT_CAP_10M_HALF          11
`define BIT_CAP_100_TWO_PAIR_FULL 10
`define BIT_CAP_100_TWO_PAIR_HALF 9
`define BIT_EXT_STATUS_PRESENT    8
`define BIT_ONE_WAY_TX_CAPABLE    7
`define BIT_NO_PREAMBLE_CAPABLE   6
`define BIT_NEGOTIATION_DONE      5
`define BIT_FAR_END_FAULT         4
`define BIT_NEGOTIATION_CAPABLE   3
`define BIT_LINK_UP_LATCHED_LOW   2
`define BIT_BABBLE_DETECTED       1
`define BIT_EXTENDED_REGS_PRESENT 0

// Reset values
`define BASIC_LINK_STATUS_RESET 16'h1009
// Arbitrary neutral identifier value
`define PHY_IDENTIFIER_HIGH_DEFAULT 16'h5AC3
`define UNMAPPED_READ_VALUE 16'h0000

// Frame field counts, in management clock periods
`define PREAMBLE_ONES 6'h20
`define OP_BITS       4'h2
`define ADDR_BITS     4'h5
`define TA_BITS       4'h2
// Sixteen does not fit the four bit field counter, so this count is one bit wider
`define DATA_BITS     5'h10

// Field codes
`define OP_CODE_READ  2'b10
`define OP_CODE_WRITE 2'b01

`endif

/* File: hdl/mii_regs_pkg.sv */
// Types shared by the management register block
package mii_regs_pkg;

	typedef enum logic [2:0]
	{
		FR_PREAMBLE,
		FR_START,
		FR_OP,
		FR_PHYAD,
		FR_REGAD,
		FR_TA,
		FR_DATA
	} frame_state_t;

	typedef logic [4:0]  reg_addr_t;
	typedef logic [15:0] reg_word_t;

endpackage : mii_regs_pkg

/* File: hdl/reg_read_if.sv */
// Read port between the frame engine and the register bank
`timescale 1ns/100ps
interface reg_read_if;
	logic                    rd_stb;
	mii_regs_pkg::reg_addr_t rd_addr;
	mii_regs_pkg::reg_word_t rd_data;

	modport requester
	(
		output rd_stb,
		output rd_addr,
		input  rd_data
	);

	modport bank
	(
		input  rd_stb,
		input  rd_addr,
		output rd_data
	);
endinterface : reg_read_if

/* File: hdl/link_status_bank.sv */
// Status and identifier register bank with the link latch
`timescale 1ns/100ps
`include "mii_regs_consts.svh"
module link_status_bank
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              link_up_internal,
	input  wire logic              negotiation_done_internal,
	input  wire logic [15:0]       id_high,
	reg_read_if.bank               rd
);

	logic link_up_latched_low_r;
	logic negotiation_done_r;

	function automatic logic is_status(input mii_regs_pkg::reg_addr_t a);
		is_status = (a == `REG_BASIC_LINK_STATUS);
	endfunction : is_status

	////////////////////////////////////////////////////////////////////////////////
	// Latch low: a failure holds the bit at 0 until a status read reloads it from the link
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			link_up_latched_low_r <= 1'b0;
		else if (rd.rd_stb && is_status(rd.rd_addr))
			link_up_latched_low_r <= link_up_internal;
		else if (!link_up_internal)
			link_up_latched_low_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			negotiation_done_r <= 1'b0;
		else
			negotiation_done_r <= negotiation_done_internal && link_up_internal;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux; the value is taken before the latch reloads
	always_comb
	begin
		rd.rd_data = `UNMAPPED_READ_VALUE;
		if (is_status(rd.rd_addr))
		begin
			rd.rd_data = 16'h0000;
			rd.rd_data[`BIT_CAP_10M_FULL]          = 1'b1;
			rd.rd_data[`BIT_NEGOTIATION_DONE]      = negotiation_done_r;
			rd.rd_data[`BIT_NEGOTIATION_CAPABLE]   = 1'b1;
			rd.rd_data[`BIT_LINK_UP_LATCHED_LOW]   = link_up_latched_low_r;
			rd.rd_data[`BIT_EXTENDED_REGS_PRESENT] = 1'b1;
		end
		else if (rd.rd_addr == `REG_PHY_IDENTIFIER_HIGH)
			rd.rd_data = id_high;
	end

endmodule : link_status_bank

/* File: hdl/mii_status_phy_id_regs.sv */
// Management frame slave serving the status and first identifier registers
//
// How it works
// - Status bits 15, 14 and 13 read 0, no 100BASE-T4 or 100BASE-X ability.
// - Status bit 12 reads 1, full duplex at 10 Mbps is supported.
// - Status bit 11 reads 0, half duplex at 10 Mbps is not supported.
// - Status bits 10 and 9 read 0, no 100BASE-T2 ability.
// - The extended status present bit reads 0, there is no register 15 status.
// - Status bit 7 reads 0, transmit only happens once a valid link is up.
// - Bit 6 reads 0 and every frame must be led by a full preamble of ones.
// - Status bit 5 mirrors negotiation done with link up and resets to 0.
// - Status bit 4, far end fault, always reads 0.
// - Status bit 3 always reads 1, negotiation can be performed.
// - Status bit 2 is link up, latched low until a status read reloads it, reset 0.
// - Status bit 1, babble detected, always reads 0.
// - Status bit 0 always reads 1, extended registers are present.
// - The status register sits at offset 1, is read only and resets to 0x1009.
// - The identifier register at offset 2 is read only and shows 16 OUI bits.
// - Registers are reached by management frames, also during power down.
`timescale 1ns/100ps
`include "mii_regs_consts.svh"
module mii_status_phy_id_regs
#(
	// Arbitrary neutral value, replace per product
	parameter logic [15:0] ID_HIGH = `PHY_IDENTIFIER_HIGH_DEFAULT
)
(
	input  wire logic       CLK_SYS,
	input  wire logic       RESETN,
	input  wire logic       MDC,
	input  wire logic       MDIO_I,
	output logic            MDIO_O,
	output logic            MDIO_OE,
	input  wire logic [4:0] PHY_ADDR,
	input  wire logic       LINK_UP,
	input  wire logic       NEGOTIATION_DONE
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	mii_regs_pkg::frame_state_t state_r;
	mii_regs_pkg::frame_state_t state_nxt;

	logic                    mdc_prev_r;
	logic                    mdc_rise;
	logic [5:0]              ones_r;
	logic [3:0]              cnt_r;
	logic [1:0]              op_r;
	logic [4:0]              phyad_r;
	logic [3:0]              regad_r;
	logic [4:0]              phy_addr_r;
	logic                    strap_taken_r;
	logic                    answer_r;
	logic                    answer_nxt;
	logic                    rd_stb_r;
	mii_regs_pkg::reg_addr_t rd_addr_r;
	mii_regs_pkg::reg_word_t data_sh_r;
	logic                    mdio_o_r;
	logic                    mdio_oe_r;
	logic                    last_field_bit;
	mii_regs_pkg::reg_addr_t regad_full;

	reg_read_if rd ();

	////////////////////////////////////////////////////////////////////////////////
	// Management clock edge; pins are already synchronous to CLK_SYS

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
			mdc_prev_r <= 1'b0;
		else
			mdc_prev_r <= MDC;
	end

	assign mdc_rise = MDC && !mdc_prev_r;

	////////////////////////////////////////////////////////////////////////////////
	// Address strap, caught once after reset release
	// Taken only once so that a strap pin reused later cannot move the address
	// in the middle of a frame.

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			phy_addr_r    <= 5'h00;
			strap_taken_r <= 1'b0;
		end
		else if (!strap_taken_r)
		begin
			phy_addr_r    <= PHY_ADDR;
			strap_taken_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame sequencer
	// No power-down input exists here, so frames are always served.
	// Limitation: a cut frame is not aborted; its field count runs on over later
	// clock rises, so the next frame may need a longer preamble to be seen.

	assign regad_full = {regad_r, MDIO_I};

	always_comb
	begin
		last_field_bit = 1'b0;
		case (state_r)
			mii_regs_pkg::FR_OP:    last_field_bit = (cnt_r == `OP_BITS - 4'h1);
			mii_regs_pkg::FR_PHYAD: last_field_bit = (cnt_r == `ADDR_BITS - 4'h1);
			mii_regs_pkg::FR_REGAD: last_field_bit = (cnt_r == `ADDR_BITS - 4'h1);
			mii_regs_pkg::FR_TA:    last_field_bit = (cnt_r == `TA_BITS - 4'h1);
			mii_regs_pkg::FR_DATA:  last_field_bit = (cnt_r == 4'(`DATA_BITS - 5'h01));
			default:                last_field_bit = 1'b0;
		endcase
	end

	always_comb
	begin
		state_nxt  = state_r;
		answer_nxt = answer_r;
		case (state_r)
			mii_regs_pkg::FR_PREAMBLE:
			begin
				// A zero only counts as start once the whole preamble was seen
				if (!MDIO_I && ones_r == `PREAMBLE_ONES)
					state_nxt = mii_regs_pkg::FR_START;
			end
			mii_regs_pkg::FR_START:
			begin
				if (MDIO_I)
					state_nxt = mii_regs_pkg::FR_OP;
				else
					state_nxt = mii_regs_pkg::FR_PREAMBLE;
			end
			mii_regs_pkg::FR_OP:
			begin
				if (last_field_bit)
					state_nxt = mii_regs_pkg::FR_PHYAD;
			end
			mii_regs_pkg::FR_PHYAD:
			begin
				if (last_field_bit)
					state_nxt = mii_regs_pkg::FR_REGAD;
			end
			mii_regs_pkg::FR_REGAD:
			begin
				if (last_field_bit)
				begin
					state_nxt = mii_regs_pkg::FR_TA;
					// Writes and foreign frames run to the end without drive
					answer_nxt = (op_r == `OP_CODE_READ) && (phyad_r == phy_addr_r);
				end
			end
			mii_regs_pkg::FR_TA:
			begin
				if (last_field_bit)
					state_nxt = mii_regs_pkg::FR_DATA;
			end
			mii_regs_pkg::FR_DATA:
			begin
				if (last_field_bit)
				begin
					state_nxt  = mii_regs_pkg::FR_PREAMBLE;
					answer_nxt = 1'b0;
				end
			end
			default:
			begin
				state_nxt  = mii_regs_pkg::FR_PREAMBLE;
				answer_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state_r  <= mii_regs_pkg::FR_PREAMBLE;
			answer_r <= 1'b0;
		end
		else if (mdc_rise)
		begin
			state_r  <= state_nxt;
			answer_r <= answer_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Preamble counter; saturates so long idle stretches stay valid

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
			ones_r <= 6'h00;
		else if (mdc_rise)
		begin
			if (state_r != mii_regs_pkg::FR_PREAMBLE)
				ones_r <= 6'h00;
			else if (!MDIO_I)
				ones_r <= 6'h00;
			else if (ones_r != `PREAMBLE_ONES)
				ones_r <= ones_r + 6'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Field bit counter
	// Held at zero in preamble so a stray count never shortens the first field

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
			cnt_r <= 4'h0;
		else if (mdc_rise)
		begin
			if (last_field_bit || state_r == mii_regs_pkg::FR_START)
				cnt_r <= 4'h0;
			else if (state_r != mii_regs_pkg::FR_PREAMBLE)
				cnt_r <= cnt_r + 4'h1;
			else
				cnt_r <= 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Header shift registers
	// The last register address bit is used live, so only four are stored

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			op_r    <= 2'b00;
			phyad_r <= 5'h00;
			regad_r <= 4'h0;
		end
		else if (mdc_rise)
		begin
			if (state_r == mii_regs_pkg::FR_OP)
				op_r <= {op_r[0], MDIO_I};
			if (state_r == mii_regs_pkg::FR_PHYAD)
				phyad_r <= {phyad_r[3:0], MDIO_I};
			if (state_r == mii_regs_pkg::FR_REGAD)
				regad_r <= {regad_r[2:0], MDIO_I};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read request: one pulse per answered read, which on a status read also releases the latch

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rd_stb_r  <= 1'b0;
			rd_addr_r <= 5'h00;
		end
		else
		begin
			rd_stb_r <= mdc_rise && state_r == mii_regs_pkg::FR_REGAD
				&& last_field_bit && answer_nxt;
			if (mdc_rise && state_r == mii_regs_pkg::FR_REGAD && last_field_bit)
				rd_addr_r <= regad_full;
		end
	end

	assign rd.rd_stb  = rd_stb_r;
	assign rd.rd_addr = rd_addr_r;

	link_status_bank u_bank
	(
		.clk                       (CLK_SYS),
		.rst_n                     (RESETN),
		.link_up_internal          (LINK_UP),
		.negotiation_done_internal (NEGOTIATION_DONE),
		.id_high                   (ID_HIGH),
		.rd                        (rd.bank)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Data shifter, loaded from the bank on the request pulse
	// The pulse lands well inside the first turnaround period, so the load never
	// meets the shift that follows a management clock rise.

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
			data_sh_r <= 16'h0000;
		else if (rd_stb_r)
			data_sh_r <= rd.rd_data;
		else if (mdc_rise && answer_r && state_r == mii_regs_pkg::FR_TA && cnt_r == 4'h1)
			data_sh_r <= {data_sh_r[14:0], 1'b0};
		else if (mdc_rise && answer_r && state_r == mii_regs_pkg::FR_DATA)
			data_sh_r <= {data_sh_r[14:0], 1'b0};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drive, changed on the rising edge so the controller samples it a period later.
	// First turnaround bit stays released to avoid a clash with the controller.

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			mdio_o_r  <= 1'b0;
			mdio_oe_r <= 1'b0;
		end
		else if (mdc_rise)
		begin
			if (!answer_r)
			begin
				mdio_o_r  <= 1'b0;
				mdio_oe_r <= 1'b0;
			end
			else if (state_r == mii_regs_pkg::FR_TA && cnt_r == 4'h0)
			begin
				mdio_o_r  <= 1'b0;
				mdio_oe_r <= 1'b1;
			end
			else if (state_r == mii_regs_pkg::FR_TA)
			begin
				mdio_o_r  <= data_sh_r[15];
				mdio_oe_r <= 1'b1;
			end
			else if (state_r == mii_regs_pkg::FR_DATA && !last_field_bit)
			begin
				mdio_o_r  <= data_sh_r[15];
				mdio_oe_r <= 1'b1;
			end
			else
			begin
				mdio_o_r  <= 1'b0;
				mdio_oe_r <= 1'b0;
			end
		end
	end

	assign MDIO_O  = mdio_o_r;
	assign MDIO_OE = mdio_oe_r;

endmodule : mii_status_phy_id_regs

/* File: tb/mii_status_phy_id_regs_sva.sv */
// Pin-level checker for the management register block
`timescale 1ns/100ps
module mii_regs_checker
#(
	parameter logic [15:0] ID_HIGH = 16'h0000
)
(
	input wire logic       CLK_SYS,
	input wire logic       RESETN,
	input wire logic       MDC,
	input wire logic       MDIO_I,
	input wire logic       MDIO_O,
	input wire logic       MDIO_OE,
	input wire logic [4:0] PHY_ADDR
);
	logic        mdc_q;
	logic        oe_q;
	logic        rise;
	logic [12:0] in_sh;
	logic [16:0] out_sh;
	logic [4:0]  reg_a;
	logic [4:0]  n_rise;

	assign rise = MDC && !mdc_q;

	////////////////////////////////////////////////////////////////////////////////
	// Shadow each frame so an answer can be tied to the address that asked for it
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			mdc_q  <= 1'b0;
			oe_q   <= 1'b0;
			in_sh  <= 13'h0000;
			out_sh <= 17'h0_0000;
			reg_a  <= 5'h00;
			n_rise <= 5'h00;
		end
		else
		begin
			mdc_q <= MDC;
			oe_q  <= MDIO_OE;
			if (rise)
				in_sh <= {in_sh[11:0], MDIO_I};
			if (rise && MDIO_OE)
				out_sh <= {out_sh[15:0], MDIO_O};
			if (MDIO_OE && !oe_q)
				reg_a <= in_sh[5:1];
			if (!MDIO_OE)
				n_rise <= 5'h00;
			else if (rise)
				n_rise <= n_rise + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	a_idle_low: assert property (!MDIO_OE |-> !MDIO_O)
		else $error("data high while released");
	a_ta_zero: assert property ($rose(MDIO_OE) |-> !MDIO_O)
		else $error("turnaround bit not zero");
	a_change_edge: assert property
		(($changed(MDIO_O) || $changed(MDIO_OE)) |-> $past(MDC) && !$past(MDC, 2))
		else $error("output moved away from a clock rise");
	a_word_len: assert property ($fell(MDIO_OE) |-> n_rise == 5'h11)
		else $error("answer not turnaround plus 16 bits");
	a_read_only: assert property
		($rose(MDIO_OE) |-> in_sh[12:11] == 2'b10 && in_sh[10:6] == PHY_ADDR)
		else $error("answer to a frame that was not ours");
	a_status_fixed: assert property
		($fell(MDIO_OE) && reg_a == 5'h01 |-> (out_sh[15:0] & 16'hFFDB) == 16'h1009)
		else $error("fixed status bits wrong");
	a_id_word: assert property
		($fell(MDIO_OE) && reg_a == 5'h02 |-> out_sh[15:0] == ID_HIGH)
		else $error("identifier word wrong");
	a_unmapped_zero: assert property
		($fell(MDIO_OE) && !(reg_a inside {5'h01, 5'h02}) |-> out_sh[15:0] == 16'h0000)
		else $error("unmapped offset not zero");

	c_status_read: cover property ($fell(MDIO_OE) && reg_a == 5'h01);
	c_id_read: cover property ($fell(MDIO_OE) && reg_a == 5'h02);
	c_other_read: cover property ($fell(MDIO_OE) && reg_a == 5'h03);
endmodule : mii_regs_checker

bind mii_status_phy_id_regs mii_regs_checker #(.ID_HIGH(ID_HIGH)) u_chk
(
	.CLK_SYS  (CLK_SYS),
	.RESETN   (RESETN),
	.MDC      (MDC),
	.MDIO_I   (MDIO_I),
	.MDIO_O   (MDIO_O),
	.MDIO_OE  (MDIO_OE),
	.PHY_ADDR (PHY_ADDR)
);

/* File: tb/mgmt_station.sv */
// Station management controller model that drives management frames
`timescale 1ns/100ps
module mgmt_station
(
	input  wire logic clk,
	output logic      mdc,
	output wire logic mdio_line,
	input  wire logic mdio_o,
	input  wire logic mdio_oe
);
	logic bit_r = 1'b1;
	logic en_r  = 1'b0;

	initial
		mdc = 1'b0;

	// Pull-up holds the line high whenever nobody drives it
	assign mdio_line = mdio_oe ? mdio_o : (en_r ? bit_r : 1'b1);

	////////////////////////////////////////////////////////////////////////////////
	// Data is set up a full low phase before the rise; sample taken as the rise goes out
	task automatic one_bit(input logic b, input logic e, output logic s);
		@(posedge clk);
		mdc   <= 1'b0;
		bit_r <= b;
		en_r  <= e;
		repeat (4) @(posedge clk);
		s = mdio_line;
		mdc <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : one_bit

	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, input int pre, output logic [15:0] rd);
		logic [31:0] f;
		logic        s;
		f = {2'b01, op, pa, ra, ((op == 2'b01) ? 2'b10 : 2'b11), wd};
		// The far end cannot skip the preamble, so every frame carries its own
		for (int i = 0; i < pre; i++)
			one_bit(1'b1, 1'b1, s);
		for (int i = 31; i >= 0; i--)
		begin
			one_bit(f[i], (op == 2'b01) || (i > 17), s);
			rd = {rd[14:0], s};
		end
		@(posedge clk);
		mdc  <= 1'b0;
		en_r <= 1'b0;
	endtask : frame
endmodule : mgmt_station

/* File: tb/mii_status_phy_id_regs_test.sv */
// Self-checking bench for the status and identifier management registers
`timescale 1ns/100ps
module mii_status_phy_id_regs_test;
	localparam logic [15:0] ID_VAL  = 16'hA55A; // Arbitrary identifier value
	localparam logic [4:0]  OWN_ADR = 5'h05;

	logic clk_sys  = 1'b0;
	logic resetn   = 1'b0;
	logic link_up  = 1'b0;
	logic neg_done = 1'b0;
	wire  mdc;
	wire  mdio_line;
	wire  mdio_o;
	wire  mdio_oe;
	int   mismatches = 0;
	int   cmp_count  = 0;
	int   cycles     = 0;

	initial
		forever #5 clk_sys = ~clk_sys;

	mii_status_phy_id_regs #(.ID_HIGH(ID_VAL)) dut
	(
		.CLK_SYS          (clk_sys),
		.RESETN           (resetn),
		.MDC              (mdc),
		.MDIO_I           (mdio_line),
		.MDIO_O           (mdio_o),
		.MDIO_OE          (mdio_oe),
		.PHY_ADDR         (OWN_ADR),
		.LINK_UP          (link_up),
		.NEGOTIATION_DONE (neg_done)
	);

	mgmt_station u_sta
	(
		.clk       (clk_sys),
		.mdc       (mdc),
		.mdio_line (mdio_line),
		.mdio_o    (mdio_o),
		.mdio_oe   (mdio_oe)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	// No answer leaves the pulled-up line, so refusals read back as all ones
	task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp,
		input logic [1:0] op = 2'b10, input logic [4:0] pa = OWN_ADR, input int pre = 32);
		logic [15:0] rd;
		u_sta.frame(op, pa, ra, 16'h0000, pre, rd);
		cmp_count++;
		if (rd !== exp)
		begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, rd, exp);
		end
	endtask : rd_reg

	task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
		logic [15:0] rd;
		u_sta.frame(2'b01, OWN_ADR, ra, wd, 32, rd);
	endtask : wr_reg

	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : hold

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			$display("ERROR at %0t: cycles %h limit %h", $time, cycles, 20000);
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		hold(10);
		resetn <= 1'b1;
		hold(2);
		rd_reg(5'h01, 16'h1009);
		$display("test reset_value done");
		link_up  <= 1'b1;
		neg_done <= 1'b1;
		hold(4);
		// First read returns the latch taken before the link came up
		rd_reg(5'h01, 16'h1029);
		rd_reg(5'h01, 16'h102D);
		link_up <= 1'b0;
		hold(4);
		link_up <= 1'b1;
		hold(4);
		rd_reg(5'h01, 16'h1029);
		rd_reg(5'h01, 16'h102D);
		neg_done <= 1'b0;
		hold(4);
		rd_reg(5'h01, 16'h100D);
		$display("test link_latch done");
		rd_reg(5'h02, ID_VAL);
		wr_reg(5'h01, 16'hFFFF);
		wr_reg(5'h02, 16'h0000);
		rd_reg(5'h01, 16'h100D);
		rd_reg(5'h02, ID_VAL);
		$display("test id_and_writes done");
		rd_reg(5'h03, 16'h0000);
		rd_reg(5'h01, 16'hFFFF, 2'b10, 5'h06);
		for (int i = 0; i < 2; i++)
			rd_reg(5'h01, 16'hFFFF, (i == 0) ? 2'b00 : 2'b11);
		rd_reg(5'h01, 16'hFFFF, 2'b10, OWN_ADR, 31);
		rd_reg(5'h01, 16'h100D);
		$display("test refusals done");
		complete_run();
	end
endmodule : mii_status_phy_id_regs_test
